// ===== verilog/dot_matrix_lcd_driver.sv
// Dot matrix LCD driver: display memory, frame sequencer and level selection.
// Assumes an AXI4-Lite master on sys_clk; analog drivers turn level codes into panel voltages.
//
// Operation
// - Drive 64 segments and 16 commons
// - One memory bit sets each dot
// - Blank panel from reset until display instruction
// - Display-off instruction blanks, memory kept
// - Display-on instruction restores stored pattern
// - Duty fixed at build, sets phases
// - Bias fixed at build, sets levels
// - Alternating clock is predivider tap three..ten
// - Frame rate is tap rate divided by duty
// - Memory is 256 nibbles from 0100h
// - Commons 1-4 and 5-8 bank layout
// - Commons push-pull or open-drain at build; the open-drain build drives a plain common only while its bit is 1
// - Commons 9-12 and 13-16 bank layout
// - Unused commons output their last-address bit
`include "lcd_drv_regs.svh"
`default_nettype none
module dot_matrix_lcd_driver #(
    parameter int SEGS = 64,
    parameter int DUTY = 16,
    parameter int BIAS = 3,
    parameter int TAP = 7,
    parameter bit COM_OPEN_DRAIN = 1'b0,
    parameter int REF_DIV = (`LCD_CLK_HZ + `LCD_REF_HZ / 2) / `LCD_REF_HZ
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [2:0] segLevel [SEGS],
    output logic [2:0] comLevel [16],
    output logic [15:0] comOut,
    output logic [15:0] comOutEn,
    output logic [15:0] comIsGpo
);
    localparam int BANKS = 4;
    localparam int MEM_WORDS = 256;

    // Build-time option checks, refused at elaboration
    // duty range check
    if (DUTY < 4 || DUTY == 7 || DUTY > 16) begin : gBadDuty
        $error("Unsupported duty");
    end
    if (BIAS < 3 || BIAS > 5) begin : gBadBias
        $error("Unsupported bias");
    end
    if (TAP < 3 || TAP > 10) begin : gBadTap
        $error("Unsupported predivider tap");
    end
    if (SEGS < 1 || SEGS > 64 || REF_DIV < 2) begin : gBadDiv
        $error("Unsupported segment count or divider");
    end

    // Reset release through two flops
    logic rstMeta_q;
    logic rstSync_q;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire logic rstN = rstSync_q;

    // Memory index of a bus byte address in the display window
    function automatic logic [7:0] memIndex(input logic [11:0] addr);
        logic [11:0] off;
        off = addr - `LCD_MEM_BASE;
        return off[9:2];
    endfunction

    function automatic logic inMem(input logic [11:0] addr);
        return addr >= `LCD_MEM_BASE && addr <= `LCD_MEM_LAST && addr[1:0] == 2'h0;
    endfunction

    // AXI4-Lite slave: address and data taken in separate handshakes, one transaction at a time
    lcd_drv_pkg::bus_state_t busState_q;
    logic [11:0] awAddr_q;
    logic awHave_q;
    logic [31:0] wData_q;
    logic wStrb0_q;
    logic wHave_q;
    logic [3:0] mem_q [MEM_WORDS];
    logic dispOff_q;
    logic shown_q;
    logic [3:0] phase_q;
    logic frameOdd_q;
    wire logic doWrite = busState_q == lcd_drv_pkg::BUS_IDLE && awHave_q && wHave_q;
    wire logic doRead = busState_q == lcd_drv_pkg::BUS_IDLE && !doWrite && s_axi_arvalid && !awHave_q && !wHave_q;

    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 12'h000;
            wData_q <= 32'h0000_0000;
            wStrb0_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !awHave_q && !s_axi_awready && busState_q == lcd_drv_pkg::BUS_IDLE) begin
                s_axi_awready <= 1'b1;
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHave_q && !s_axi_wready && busState_q == lcd_drv_pkg::BUS_IDLE) begin
                s_axi_wready <= 1'b1;
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb0_q <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
            end
        end
    end

    // Response channels
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            busState_q <= lcd_drv_pkg::BUS_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lcd_drv_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= lcd_drv_pkg::RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            s_axi_arready <= 1'b0;
            unique case (busState_q)
                lcd_drv_pkg::BUS_IDLE: begin
                    if (doWrite) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (inMem(awAddr_q) || awAddr_q == `LCD_CTRL_OFFSET)
                            ? lcd_drv_pkg::RESP_OKAY : lcd_drv_pkg::RESP_SLVERR;
                        busState_q <= lcd_drv_pkg::BUS_WRESP;
                    end else if (doRead) begin
                        s_axi_arready <= 1'b1;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rresp <= lcd_drv_pkg::RESP_OKAY;
                        s_axi_rdata <= 32'h0000_0000;
                        if (inMem(s_axi_araddr))
                            s_axi_rdata <= {28'h0000000, mem_q[memIndex(s_axi_araddr)]};
                        else if (s_axi_araddr == `LCD_CTRL_OFFSET)
                            s_axi_rdata <= {31'h00000000, dispOff_q};
                        else if (s_axi_araddr == `LCD_STATUS_OFFSET)
                            s_axi_rdata <= {27'h0000000, frameOdd_q, phase_q};
                        else
                            s_axi_rresp <= lcd_drv_pkg::RESP_SLVERR;
                        busState_q <= lcd_drv_pkg::BUS_RRESP;
                    end
                end
                lcd_drv_pkg::BUS_WRESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        busState_q <= lcd_drv_pkg::BUS_IDLE;
                    end
                end
                lcd_drv_pkg::BUS_RRESP: begin
                    if (s_axi_rready) begin
                        s_axi_rvalid <= 1'b0;
                        busState_q <= lcd_drv_pkg::BUS_IDLE;
                    end
                end
                default: busState_q <= lcd_drv_pkg::BUS_IDLE;
            endcase
        end
    end

    // Display memory, one nibble per word; contents survive display-off
    // 256 nibble store
    always_ff @(posedge sys_clk) begin
        if (doWrite && wStrb0_q && inMem(awAddr_q))
            mem_q[memIndex(awAddr_q)] <= wData_q[3:0];
    end

    // Display control: blank until first control write, then follow the off bit
    // blank until instruction
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            dispOff_q <= `LCD_CTRL_RESET;
            shown_q <= 1'b0;
        end else if (doWrite && wStrb0_q && awAddr_q == `LCD_CTRL_OFFSET) begin
            dispOff_q <= wData_q[`LCD_CTRL_OFF_BIT];
            shown_q <= 1'b1;
        end
    end

    // Reference tick at 32768 Hz from the system clock
    logic [15:0] refCnt_q;
    logic refTick_q;
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            refCnt_q <= 16'h0000;
            refTick_q <= 1'b0;
        end else begin
            refTick_q <= refCnt_q == 16'(REF_DIV - 1);
            refCnt_q <= (refCnt_q == 16'(REF_DIV - 1)) ? 16'h0000 : refCnt_q + 16'h0001;
        end
    end

    // Predivider: alternating clock tick once per tap period
    // tap selects period
    // frame rate from tap and duty
    logic [10:0] preDiv_q;
    logic altTick_q;
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            preDiv_q <= 11'h000;
            altTick_q <= 1'b0;
        end else begin
            altTick_q <= 1'b0;
            if (refTick_q) begin
                preDiv_q <= preDiv_q + 11'h001;
                altTick_q <= preDiv_q[TAP - 1:0] == '1;
            end
        end
    end

    // Common phase sequencer with per-frame polarity inversion
    // phase and polarity
    always_ff @(posedge sys_clk or negedge rstN) begin
        if (!rstN) begin
            phase_q <= 4'h0;
            frameOdd_q <= 1'b0;
        end else if (altTick_q) begin
            if (phase_q == 4'(DUTY - 1)) begin
                phase_q <= 4'h0;
                frameOdd_q <= ~frameOdd_q;
            end else begin
                phase_q <= phase_q + 4'h1;
            end
        end
    end

    // Level codes: 0 is ground, BIAS is the top rail; select sits at the rails
    localparam logic [2:0] TOP = 3'(BIAS);
    localparam logic [2:0] COM_NS_LO = 3'h1;
    localparam logic [2:0] COM_NS_HI = 3'(BIAS - 1);
    localparam logic [2:0] SEG_NS_LO = 3'h2;
    localparam logic [2:0] SEG_NS_HI = 3'(BIAS - 2);
    wire logic blank = !shown_q || dispOff_q;

    // Segment drive from the memory bit of the active common
    // segment outputs
    for (genvar s = 0; s < SEGS; s++) begin : gSeg
        wire logic [7:0] idx = 8'({phase_q[3:2], 6'(s)});
        wire logic dotOn = mem_q[idx][phase_q[1:0]] && !blank;
        always_ff @(posedge sys_clk or negedge rstN) begin
            if (!rstN)
                segLevel[s] <= SEG_NS_LO;
            else if (frameOdd_q)
                segLevel[s] <= dotOn ? 3'h0 : SEG_NS_HI;
            else
                segLevel[s] <= dotOn ? TOP : SEG_NS_LO;
        end
    end

    // Common drive and plain outputs for commons beyond the duty
    // common outputs
    for (genvar c = 0; c < 16; c++) begin : gCom
        wire logic active = phase_q == 4'(c);
        wire logic gpoBit = mem_q[8'({2'(c / 4), 6'h3F})][c % 4];
        always_ff @(posedge sys_clk or negedge rstN) begin
            if (!rstN) begin
                comLevel[c] <= COM_NS_LO;
                comOut[c] <= 1'b0;
                comOutEn[c] <= 1'b0;
                comIsGpo[c] <= 1'b0;
            end else begin
                comIsGpo[c] <= c >= DUTY;
                comOut[c] <= gpoBit;
                comOutEn[c] <= c >= DUTY && (!COM_OPEN_DRAIN || gpoBit);
                if (c >= DUTY)
                    comLevel[c] <= gpoBit ? TOP : 3'h0;
                else if (frameOdd_q)
                    comLevel[c] <= active ? TOP : COM_NS_LO;
                else
                    comLevel[c] <= active ? 3'h0 : COM_NS_HI;
            end
        end
    end
endmodule
`default_nettype wire

// ===== include/lcd_drv_regs.svh
// Register offsets, field positions, reset values and timing counts of the dot matrix LCD driver.
// Assumes a 32-bit AXI4-Lite slave port and a 10 MHz system clock.
`ifndef LCD_DRV_REGS_SVH
`define LCD_DRV_REGS_SVH

`define LCD_CTRL_OFFSET 12'h000
`define LCD_STATUS_OFFSET 12'h004
`define LCD_MEM_BASE 12'h400
`define LCD_MEM_LAST 12'h7FC
`define LCD_CTRL_OFF_BIT 0
`define LCD_CTRL_RESET 1'b1
`define LCD_REF_HZ 32768
`define LCD_CLK_HZ 10000000
`define LCD_DISP_BASE 12'h100
`define LCD_BANK_STRIDE 12'h040
`define LCD_DISP_OFF_OPERAND 4'h4

`endif

// ===== include/lcd_drv_pkg.sv
// Types shared by the dot matrix LCD driver.
// Assumes nothing of its surroundings.
`default_nettype none
package lcd_drv_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRESP,
        BUS_RRESP
    } bus_state_t;
    typedef logic [1:0] resp_t;
    localparam resp_t RESP_OKAY = 2'h0;
    localparam resp_t RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ===== verification/lcd_drv_props.sv
// Concurrent checks on the LCD driver's bus handshakes and common pins.
// Assumes it is bound into dot_matrix_lcd_driver.
`default_nettype none
module lcd_drv_props #(parameter int DUTY = 16, parameter int BIAS = 3) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [2:0] comLevel [16],
    input wire logic [15:0] comOutEn,
    input wire logic [15:0] comIsGpo
);
    logic [15:0] gpoMask;
    int selCnt;
    // Plain-output mask and number of scanning commons at a select level
    always_comb begin
        selCnt = 0;
        for (int i = 0; i < 16; i++) begin
            gpoMask[i] = (i >= DUTY);
            if (i < DUTY && (comLevel[i] == 3'h0 || comLevel[i] == 3'(BIAS))) selCnt++;
        end
    end
    chk_bvalid_stands: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    chk_rvalid_stands: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
    chk_write_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_axi_awready && s_axi_wready |=> s_axi_bvalid) else $error("no write answer");
    chk_read_answer: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_axi_arready |-> s_axi_rvalid) else $error("no read answer");
    chk_ready_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_axi_awready |=> !s_axi_awready) else $error("awready held");
    chk_gpo_map: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(rst_b, 4) |-> comIsGpo == gpoMask) else $error("wrong plain commons");
    chk_drive_enable: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $past(rst_b, 4) |-> comOutEn == comIsGpo) else $error("push-pull enable wrong");
    chk_one_select: assert property (@(posedge sys_clk) disable iff (!rst_b)
        selCnt <= 1) else $error("several commons selected");
endmodule
bind dot_matrix_lcd_driver lcd_drv_props #(.DUTY(DUTY), .BIAS(BIAS)) props (.sys_clk, .rst_b,
    .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .comLevel, .comOutEn, .comIsGpo);
`default_nettype wire

// ===== verification/lcd_panel_model.sv
// Passive dot matrix panel: marks each dot that sees the full bias span.
// Assumes level codes 0..BIAS; commons at or above DUTY do not scan.
`default_nettype none
module lcd_panel_model #(parameter int DUTY = 16, parameter int BIAS = 3) (
    input wire logic sys_clk,
    input wire logic clear,
    input wire logic [2:0] segLevel [64],
    input wire logic [2:0] comLevel [16],
    output logic [1023:0] litMap,
    output logic [10:0] litCount
);
    // Sticky lit marks, cleared on request
    always_ff @(posedge sys_clk) begin
        for (int s = 0; s < 64; s++) begin
            for (int c = 0; c < 16; c++) begin
                if (clear) litMap[s*16+c] <= 1'h0;
                else if (c < DUTY && (segLevel[s] == comLevel[c] + 3'(BIAS) ||
                         comLevel[c] == segLevel[s] + 3'(BIAS))) litMap[s*16+c] <= 1'h1;
            end
        end
    end
    assign litCount = 11'($countones(litMap));
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the dot matrix LCD driver.
// Assumes the driver, its bound checker and the panel model.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // tap seven, duty 1/8, reference tick every 2 cycles: 2048-cycle frames
    localparam int FRAME = 2048;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic clear = 1'h0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, d0, d1, d2;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [2:0] segLevel [64];
    logic [2:0] comLevel [16];
    logic [15:0] comOut;
    logic [1023:0] litMap;
    logic [10:0] litCount;
    int errTotal = 0, checks = 0, cyc = 0, st;
    dot_matrix_lcd_driver #(.DUTY(8), .REF_DIV(2)) uut (.sys_clk, .rst_b, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .segLevel, .comLevel, .comOut, .comOutEn(), .comIsGpo());
    lcd_panel_model #(.DUTY(8)) panel (.sys_clk, .clear, .segLevel, .comLevel, .litMap, .litCount);
    // Clock and cycle count
    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        bready <= 1'h0;
        check_val(32'(bresp), 32'h0, "write resp");
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        rready <= 1'h0;
        d = rdata;
        rs = rresp;
    endtask
    task automatic frame_lit(input logic [10:0] n);
        @(posedge sys_clk) clear <= 1'h1;
        @(posedge sys_clk) clear <= 1'h0;
        repeat (FRAME + 64) @(posedge sys_clk);
        check_val(32'(litCount), 32'(n), "lit dots");
    endtask
    task automatic t_memory();
        for (int i = 0; i < 256; i++) wr(12'(12'h400 + 4 * i), 32'h0, 4'hF);
        wr(12'h400, 32'hFFFFFFF1, 4'hF);
        wr(12'h400, 32'h0, 4'hE);
        rd(12'h400, d0, r);
        check_val(d0, 32'h1, "nibble kept");
        rd(12'h008, d0, r);
        check_val(32'(r), 32'h2, "unmapped");
    endtask
    task automatic t_dots();
        wr(12'h5FC, 32'h8, 4'hF);
        wr(12'h6FC, 32'hA, 4'hF);
        wr(12'h7FC, 32'h5, 4'hF);
        wr(12'h000, 32'h0, 4'hF);
        frame_lit(11'h2);
        check_val(32'(litMap[0]), 32'h1, "seg1 com1");
        check_val(32'(litMap[63*16+7]), 32'h1, "seg64 com8");
        check_val(32'(comOut[15:8]), 32'h5A, "plain commons");
    endtask
    task automatic t_off_on();
        wr(12'h000, 32'h1, 4'hF);
        frame_lit(11'h0);
        check_val(32'(comOut[15:8]), 32'h5A, "plain while off");
        rd(12'h5FC, d0, r);
        check_val(d0, 32'h8, "memory kept");
        wr(12'h000, 32'h0, 4'hF);
        frame_lit(11'h2);
    endtask
    task automatic t_timing();
        // Reads are sampled exactly 256 and FRAME cycles after the first one
        st = cyc;
        rd(12'h004, d0, r);
        wait (cyc == st + 257);
        rd(12'h004, d1, r);
        wait (cyc == st + FRAME + 1);
        rd(12'h004, d2, r);
        check_val(d1[3:0], (d0[3:0] + 4'h1) & 4'h7, "phase step");
        check_val(d2[4:0], {~d0[4], d0[3:0]}, "frame flip");
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'h1;
        repeat (3) @(posedge sys_clk);
        frame_lit(11'h0);
        t_memory();
        t_dots();
        t_off_on();
        t_timing();
        give_verdict();
    end
    // Watchdog
    initial begin
        repeat (40000) @(posedge sys_clk);
        errTotal++;
        give_verdict();
    end
endmodule
`default_nettype wire
